/* File: logic/bmd_decode.sv */
// Combinational address decoder for the boot mode map.
// Assumes mode inputs are stable registers of the same clock.
`timescale 1ns/1ps
`include "bmd_defines.svh"
module bmd_decode
  import bmd_pkg::*;
(
  input  wire logic [31:0] addr_i,
  input  wire logic [1:0]  size_i,
  input  wire logic        rom_en_i,
  input  wire logic        single_i,
  input  wire logic [31:0] ram_limit_i,
  output bmd_region_t      region_o,
  output logic             direct_o
);
  logic [31:0] exec_base;
  logic [31:0] stack_end;

  assign exec_base = `BMD_STACK_BASE - `BMD_EXEC_SIZE;
  assign stack_end = `BMD_STACK_BASE + `BMD_STACK_SIZE;

  always_comb begin
    case (size_i)
      2'h0:    direct_o = (addr_i <= `BMD_DIRECT_BYTE_END);
      2'h1:    direct_o = (addr_i <= `BMD_DIRECT_HALF_END);
      default: direct_o = (addr_i <= `BMD_DIRECT_WORD_END);
    endcase
  end

  // Full 32-bit compare, no aliasing anywhere in 4 GB
  always_comb begin
    region_o = BMD_RGN_NONE;
    if (addr_i < `BMD_IO_END) begin
      region_o = BMD_RGN_IO;
    end else if (addr_i >= exec_base && addr_i < `BMD_STACK_BASE) begin
      if (addr_i - exec_base < ram_limit_i) begin
        region_o = BMD_RGN_EXEC_RAM;
      end
    end else if (addr_i >= `BMD_STACK_BASE && addr_i < stack_end) begin
      if (addr_i - `BMD_STACK_BASE < ram_limit_i) begin
        region_o = BMD_RGN_STACK_RAM;
      end
    end else if (addr_i >= `BMD_EXT_LO_BASE && addr_i < `BMD_EXT_LO_END) begin
      if (!single_i && rom_en_i) begin
        region_o = BMD_RGN_EXT;
      end
    end else if (addr_i >= `BMD_ROM_BASE && addr_i < `BMD_ROM_END) begin
      if (rom_en_i) begin
        region_o = BMD_RGN_ROM;
      end else if (!single_i) begin
        region_o = BMD_RGN_EXT;
      end
    end else if (addr_i >= `BMD_ROM_END && !single_i) begin
      region_o = BMD_RGN_EXT;
    end
  end
endmodule

/* File: logic/bmd_defines.svh */
// Constants of the boot mode loader and address decoder.
// Assumes inclusion by bare name from logic/ sources only.
// Function
// - Mode pins 000 fetch vectors internally, 001 fetch them externally.
// - Mode data is read from the fixed vector address into boot mode reg.
// - Device runs in the stored mode only after the post-reset fetch.
// - Boot mode register reloads on every reset; software writes ignored.
// - ROM enable 0: fast RAM active, ROM range goes to external bus unless single chip (then it decodes to no region).
// - ROM enable 1: fast RAM and ROM both decode as on-chip memory.
// - Width bits: 00 8-bit, 01 16-bit, 10 disallowed, 11 single chip.
// - External bus mode copies width bits into area-0 width field.
// - CPU sees a 4 GB linear space of 32-bit byte addresses.
// - Direct area reaches 0FF byte, 1FF halfword, 3FF word.
// - 16 KB stack RAM maps at 0004_0000 in every mode.
// - 8 KB executable RAM maps directly below stack RAM always.
// - Usable internal RAM restricted after reset until software widens.
`ifndef BMD_DEFINES_SVH
`define BMD_DEFINES_SVH

// ***************************************************
// Fetch and decode constants
// ***************************************************
`define BMD_MODE_VEC_ADDR   32'h000F_FFF8
`define BMD_MODE_INTERNAL   3'h0
`define BMD_MODE_EXTERNAL   3'h1
`define BMD_BIT_ROM_EN      2
`define BMD_BIT_WIDTH_HI    1
`define BMD_BIT_WIDTH_LO    0
`define BMD_SYNC_WAIT       2'h2
`define BMD_RSVD_MSB        7
`define BMD_RSVD_LSB        3
`define BMD_IO_BASE         32'h0000_0000
`define BMD_IO_END          32'h0001_0000
`define BMD_DIRECT_BYTE_END 32'h0000_00FF
`define BMD_DIRECT_HALF_END 32'h0000_01FF
`define BMD_DIRECT_WORD_END 32'h0000_03FF
`define BMD_STACK_BASE      32'h0004_0000
`define BMD_STACK_SIZE      32'h0000_4000
`define BMD_EXEC_SIZE       32'h0000_2000
`define BMD_EXT_LO_BASE     32'h0005_0000
`define BMD_EXT_LO_END      32'h0008_0000
`define BMD_ROM_BASE        32'h0008_0000
`define BMD_ROM_END         32'h0010_0000
`define BMD_RAM_LIMIT_RST   32'h0000_1000

// ***************************************************
// Register offsets
// ***************************************************
`define BMD_REG_MODE        12'h000
`define BMD_REG_STATUS      12'h004
`define BMD_REG_RAM_LIMIT   12'h008
`define BMD_REG_AREA0       12'h00C
`define BMD_REG_PROBE       12'h010
`define BMD_REG_DECODE      12'h014

`endif

/* File: logic/bmd_pkg.sv */
// Types of the boot mode loader and address decoder.
// Assumes bmd_defines.svh for all numeric constants.
package bmd_pkg;
  typedef enum logic [1:0] {
    BMD_BUS_8,
    BMD_BUS_16,
    BMD_BUS_BAD,
    BMD_BUS_SINGLE
  } bmd_bus_t;

  typedef enum logic [2:0] {
    BMD_RGN_NONE,
    BMD_RGN_IO,
    BMD_RGN_EXEC_RAM,
    BMD_RGN_STACK_RAM,
    BMD_RGN_ROM,
    BMD_RGN_EXT
  } bmd_region_t;
endpackage

/* File: logic/bmd_sync.sv */
// Two-stage synchroniser for the mode select pins.
// Assumes pins are static around reset release.
`timescale 1ns/1ps
module bmd_sync #(
  parameter int W = 3
) (
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

/* File: logic/bmd_top.sv */
// Boot mode loader with AXI4-Lite register access and address decoder.
// Assumes a boot memory read port answering with a one-shot valid.
`timescale 1ns/1ps
`include "bmd_defines.svh"
module bmd_top
  import bmd_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [2:0]  mode_select_pin_i,
  output logic             boot_rd_req_o,
  output logic [31:0]      boot_rd_addr_o,
  output logic             boot_rd_ext_o,
  input  wire logic        boot_rd_valid_i,
  input  wire logic [7:0]  boot_rd_data_i,
  output logic             mode_ready_o,
  output logic             mode_error_o,
  output logic [1:0]       area0_width_o,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  // ***************************************************
  // Mode pins and fetch sequencer
  // ***************************************************
  typedef enum logic [1:0] {
    BMD_ST_WAIT,
    BMD_ST_FETCH,
    BMD_ST_RUN
  } bmd_state_t;

  bmd_state_t  state_r;
  logic [2:0]  mode_pins_s;
  logic [7:0]  boot_mode_reg;
  logic        pins_bad_r;

  bmd_sync #(.W(3)) u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (mode_select_pin_i),
    .sync_o    (mode_pins_s)
  );

  // Both synchroniser stages reset to zero, so the pins need two
  // edges after release before they can be trusted
  logic [1:0] wait_cnt_r;
  logic       wait_done;

  assign wait_done = (wait_cnt_r == `BMD_SYNC_WAIT);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_cnt_r <= 2'h0;
    end else if (!wait_done) begin
      wait_cnt_r <= wait_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= BMD_ST_WAIT;
    end else begin
      case (state_r)
        BMD_ST_WAIT:  if (wait_done) state_r <= BMD_ST_FETCH;
        BMD_ST_FETCH: if (boot_rd_valid_i) state_r <= BMD_ST_RUN;
        default:      state_r <= BMD_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      boot_rd_req_o  <= 1'b0;
      boot_rd_addr_o <= 32'h0000_0000;
      boot_rd_ext_o  <= 1'b0;
      pins_bad_r     <= 1'b0;
    end else if (state_r == BMD_ST_WAIT && wait_done) begin
      boot_rd_req_o  <= 1'b1;
      boot_rd_addr_o <= `BMD_MODE_VEC_ADDR;
      boot_rd_ext_o  <= (mode_pins_s == `BMD_MODE_EXTERNAL);
      // Forbidden combinations fall back to internal fetch, flagged
      pins_bad_r     <= (mode_pins_s != `BMD_MODE_INTERNAL) &&
                        (mode_pins_s != `BMD_MODE_EXTERNAL);
    end else if (state_r == BMD_ST_FETCH && boot_rd_valid_i) begin
      boot_rd_req_o  <= 1'b0;
    end
  end

  // Cleared by every reset, written only by the fetch
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      boot_mode_reg <= 8'h00;
    end else if (state_r == BMD_ST_FETCH && boot_rd_valid_i) begin
      boot_mode_reg <= boot_rd_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_ready_o <= 1'b0;
    end else begin
      mode_ready_o <= (state_r == BMD_ST_RUN);
    end
  end

  // ***************************************************
  // Mode decode
  // ***************************************************
  logic       running;
  logic       onchip_rom_enable;
  logic       boot_width_hi;
  logic       boot_width_lo;
  logic [1:0] fetch_width;
  logic       rom_en;
  bmd_bus_t   bus_mode;
  logic       single;
  logic       rsvd_bad;

  // ***************************************************
  // Boot mode fields
  // ***************************************************
  assign onchip_rom_enable = boot_mode_reg[`BMD_BIT_ROM_EN];
  assign boot_width_hi     = boot_mode_reg[`BMD_BIT_WIDTH_HI];
  assign boot_width_lo     = boot_mode_reg[`BMD_BIT_WIDTH_LO];
  // Width bits of the byte on the fetch port, copied as it lands
  assign fetch_width = {boot_rd_data_i[`BMD_BIT_WIDTH_HI],
                        boot_rd_data_i[`BMD_BIT_WIDTH_LO]};

  assign running  = (state_r == BMD_ST_RUN);
  assign rom_en   = running & onchip_rom_enable;
  assign bus_mode = bmd_bus_t'({boot_width_hi, boot_width_lo});
  assign single   = running & (bus_mode == BMD_BUS_SINGLE);
  // Upper bits must be zero; anything else is only reported
  assign rsvd_bad =
    |boot_mode_reg[`BMD_RSVD_MSB:`BMD_RSVD_LSB];

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_error_o <= 1'b0;
    end else begin
      mode_error_o <= running &
        (rsvd_bad | (bus_mode == BMD_BUS_BAD) | pins_bad_r);
    end
  end

  // Area-0 width takes the fetched width bits unless they read 11 (single chip)
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      area0_width_o <= 2'h0;
    end else if (state_r == BMD_ST_FETCH && boot_rd_valid_i &&
                 fetch_width != 2'h3) begin
      area0_width_o <= fetch_width;
    end
  end

  // ***************************************************
  // RAM window limit, software widened
  // ***************************************************
  logic [31:0] ram_limit_r;
  logic [31:0] probe_addr_r;
  logic [1:0]  probe_size_r;
  logic        wr_fire;
  logic [11:0] wr_addr_r;
  logic [31:0] wr_data_r;
  logic [3:0]  wr_strb_r;
  logic        aw_held_r;
  logic        w_held_r;

  assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ram_limit_r <= `BMD_RAM_LIMIT_RST;
    end else if (wr_fire && wr_addr_r == `BMD_REG_RAM_LIMIT) begin
      ram_limit_r <= wr_data_r;
    end
  end

  // Probe lets software ask the decoder about any address
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      probe_addr_r <= 32'h0000_0000;
      probe_size_r <= 2'h0;
    end else if (wr_fire && wr_addr_r == `BMD_REG_PROBE) begin
      probe_addr_r <= wr_data_r;
    end else if (wr_fire && wr_addr_r == `BMD_REG_DECODE) begin
      probe_size_r <= wr_data_r[1:0];
    end
  end

  bmd_region_t probe_region;
  logic        probe_direct;

  bmd_decode u_decode (
    .addr_i      (probe_addr_r),
    .size_i      (probe_size_r),
    .rom_en_i    (rom_en),
    .single_i    (single),
    .ram_limit_i (ram_limit_r),
    .region_o    (probe_region),
    .direct_o    (probe_direct)
  );

  // ***************************************************
  // AXI4-Lite write channel
  // ***************************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held_r <= 1'b0;
      wr_addr_r <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      wr_addr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      w_held_r  <= 1'b0;
      wr_data_r <= 32'h0000_0000;
      wr_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r  <= 1'b1;
      wr_data_r <= s_axi_wdata;
      wr_strb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_r & ~(s_axi_awvalid & s_axi_awready)
                       & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held_r & ~(s_axi_wvalid & s_axi_wready)
                       & ~s_axi_bvalid;
    end
  end

  // ***************************************************
  // Write response
  // ***************************************************
  logic wr_ok;

  // Only three offsets take writes; the mode register is not one
  always_comb begin
    wr_ok = 1'b0;
    if (wr_addr_r == `BMD_REG_RAM_LIMIT) begin
      wr_ok = 1'b1;
    end else if (wr_addr_r == `BMD_REG_PROBE) begin
      wr_ok = 1'b1;
    end else if (wr_addr_r == `BMD_REG_DECODE) begin
      wr_ok = 1'b1;
    end
  end

  // Mode register write answers SLVERR and changes nothing
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (wr_ok) begin
        s_axi_bresp <= 2'h0;
      end else begin
        s_axi_bresp <= 2'h2;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ***************************************************
  // AXI4-Lite read channel
  // ***************************************************
  // Unmapped offsets read zero with SLVERR
  logic [31:0] rd_mux;
  logic        rd_hit;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == `BMD_REG_MODE) begin
      rd_mux = {24'h00_0000, boot_mode_reg};
    end else if (s_axi_araddr == `BMD_REG_STATUS) begin
      rd_mux = {27'h000_0000, pins_bad_r, rsvd_bad, single, rom_en, running};
    end else if (s_axi_araddr == `BMD_REG_RAM_LIMIT) begin
      rd_mux = ram_limit_r;
    end else if (s_axi_araddr == `BMD_REG_AREA0) begin
      rd_mux = {30'h0000_0000, area0_width_o};
    end else if (s_axi_araddr == `BMD_REG_PROBE) begin
      rd_mux = probe_addr_r;
    end else if (s_axi_araddr == `BMD_REG_DECODE) begin
      rd_mux = {26'h000_0000, probe_direct, probe_region, probe_size_r};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* File: tb/bmd_boot_mem.sv */
// Boot memory model holding the mode data byte.
// Assumes a request held until its one-cycle valid pulse.
`timescale 1ns/1ps
module bmd_boot_mem (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       req_i,
  input  wire logic [7:0] mode_data_i,
  input  wire logic [3:0] delay_i,
  output logic            valid_o,
  output logic [7:0]      data_o
);
  logic [3:0] wait_r;
  logic       done_r;
  // Data line inverts every cycle outside the pulse, so the byte right after the pulse never matches it
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      valid_o <= 1'b0;
      data_o  <= 8'h00;
      wait_r  <= 4'h0;
      done_r  <= 1'b0;
    end else begin
      valid_o <= 1'b0;
      data_o  <= ~data_o;
      if (!req_i) begin
        wait_r <= 4'h0;
        done_r <= 1'b0;
      end else if (!done_r && wait_r == delay_i) begin
        valid_o <= 1'b1;
        data_o  <= mode_data_i;
        done_r  <= 1'b1;
      end else if (!done_r) begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule

/* File: tb/bmd_chk.sv */
// Checker of the boot fetch and mode outputs of bmd_top.
// Assumes it is bound to bmd_top and sees its ports only.
`timescale 1ns/1ps
module bmd_chk (
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  input wire logic [2:0]  mode_select_pin_i,
  input wire logic        boot_rd_req_o,
  input wire logic [31:0] boot_rd_addr_o,
  input wire logic        boot_rd_ext_o,
  input wire logic        boot_rd_valid_i,
  input wire logic [7:0]  boot_rd_data_i,
  input wire logic        mode_ready_o,
  input wire logic        mode_error_o,
  input wire logic [1:0]  area0_width_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ****************
  // Fetch steps
  // ****************
  sequence s_take;
    boot_rd_req_o && boot_rd_valid_i;
  endsequence
  sequence s_load;
    !boot_rd_req_o ##1 mode_ready_o;
  endsequence
  a_fetch_addr: assert property (
    boot_rd_req_o |-> boot_rd_addr_o == 32'h000F_FFF8)
    else $error("fetch address wrong");
  a_fetch_src: assert property (
    $rose(boot_rd_req_o) |-> boot_rd_ext_o == (mode_select_pin_i == 3'h1))
    else $error("fetch source wrong");
  a_req_holds: assert property (
    boot_rd_req_o && !boot_rd_valid_i |=> boot_rd_req_o)
    else $error("fetch request dropped early");
  a_load_order: assert property (s_take |=> s_load)
    else $error("mode not loaded after fetch");
  a_ready_cause: assert property (
    $rose(mode_ready_o) |-> $past(boot_rd_valid_i, 2))
    else $error("mode ready without fetch");
  a_ready_keeps: assert property (
    mode_ready_o |=> mode_ready_o && !boot_rd_req_o)
    else $error("mode ready lost or refetch");
  a_width_copy: assert property (
    s_take ##0 !boot_rd_data_i[1]
      |-> ##2 area0_width_o == $past(boot_rd_data_i[1:0], 2))
    else $error("area0 width not copied");
  a_bad_width: assert property (
    s_take ##0 boot_rd_data_i[1:0] == 2'b10 |-> ##2 mode_error_o)
    else $error("disallowed width not flagged");
  a_good_mode: assert property (
    s_take ##0 (boot_rd_data_i[7:3] == 5'h00 && boot_rd_data_i[1:0] != 2'b10
      && mode_select_pin_i[2:1] == 2'b00) |-> ##2 !mode_error_o)
    else $error("legal mode flagged");
endmodule

bind bmd_top bmd_chk u_chk (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .mode_select_pin_i(mode_select_pin_i), .boot_rd_req_o(boot_rd_req_o),
  .boot_rd_addr_o(boot_rd_addr_o), .boot_rd_ext_o(boot_rd_ext_o),
  .boot_rd_valid_i(boot_rd_valid_i), .boot_rd_data_i(boot_rd_data_i),
  .mode_ready_o(mode_ready_o), .mode_error_o(mode_error_o),
  .area0_width_o(area0_width_o));

/* File: tb/bmd_top_bench.sv */
// Testbench of bmd_top: boots each mode and probes registers and map.
// Assumes bmd_chk is bound and bmd_boot_mem answers the fetch.
`timescale 1ns/1ps
module bmd_top_bench;
  logic        sys_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [2:0]  pins      = 3'h0;
  logic [7:0]  cfg       = 8'h00;
  logic [3:0]  dly       = 4'h0;
  logic        req, ext, valid, ready, err;
  logic [31:0] raddr;
  logic [7:0]  bdata;
  logic [1:0]  width;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr  = 12'h000, araddr = 12'h000;
  logic [31:0] wdata   = 32'h0000_0000, rdata;
  logic [1:0]  bresp, rresp;
  int          miscompares = 0, comparisons = 0, cycles = 0;

  always #25 sys_clk_i = ~sys_clk_i;

  bmd_top uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .mode_select_pin_i(pins), .boot_rd_req_o(req),
    .boot_rd_addr_o(raddr), .boot_rd_ext_o(ext),
    .boot_rd_valid_i(valid), .boot_rd_data_i(bdata),
    .mode_ready_o(ready), .mode_error_o(err), .area0_width_o(width),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp));

  bmd_boot_mem u_mem (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .req_i(req), .mode_data_i(cfg), .delay_i(dly), .valid_o(valid),
    .data_o(bdata));

  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge sys_clk_i);
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge sys_clk_i);
  endtask

  // Region code and direct flag for an address at a given access size
  task automatic probe(input logic [31:0] a, input logic [1:0] sz,
                       input logic [2:0] rg, input logic dr);
    axi_wr(12'h010, a, 2'b00);
    axi_wr(12'h014, {30'h0, sz}, 2'b00);
    axi_rd(12'h014, {26'h0, dr, rg, sz}, 2'b00);
  endtask

  task automatic boot(input logic [2:0] p, input logic [7:0] d,
                      input logic [3:0] w);
    reset_n_i <= 1'b0;
    pins      <= p;
    cfg       <= d;
    dly       <= w;
    repeat (16) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    do @(posedge sys_clk_i); while (ready !== 1'b1);
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  // ****************
  // Tests
  // ****************
  initial begin
    boot(3'h0, 8'h04, 4'h0);
    chk({31'h0, err}, 32'h0);
    axi_rd(12'h000, 32'h04, 2'b00);
    axi_rd(12'h004, 32'h03, 2'b00);
    axi_rd(12'h00C, 32'h00, 2'b00);
    axi_wr(12'h000, 32'hFF, 2'b10);
    axi_rd(12'h000, 32'h04, 2'b00);
    axi_rd(12'h020, 32'h00, 2'b10);
    probe(32'h0004_0FFF, 2'd2, 3'd3, 1'b0);
    probe(32'h0004_1000, 2'd2, 3'd0, 1'b0);
    axi_wr(12'h008, 32'h4000, 2'b00);
    probe(32'h0004_3FFF, 2'd2, 3'd3, 1'b0);
    probe(32'h0004_4000, 2'd2, 3'd0, 1'b0);
    probe(32'h0003_E000, 2'd2, 3'd2, 1'b0);
    probe(32'h0003_DFFF, 2'd2, 3'd0, 1'b0);
    probe(32'h0008_0000, 2'd2, 3'd4, 1'b0);
    probe(32'h0005_0000, 2'd2, 3'd5, 1'b0);
    probe(32'hFFFF_FFFF, 2'd2, 3'd5, 1'b0);
    probe(32'h0000_00FF, 2'd0, 3'd1, 1'b1);
    probe(32'h0000_0100, 2'd0, 3'd1, 1'b0);
    probe(32'h0000_01FF, 2'd1, 3'd1, 1'b1);
    probe(32'h0000_0200, 2'd1, 3'd1, 1'b0);
    probe(32'h0000_03FF, 2'd2, 3'd1, 1'b1);
    probe(32'h0000_0400, 2'd2, 3'd1, 1'b0);
    boot(3'h1, 8'h01, 4'h5);
    axi_rd(12'h008, 32'h1000, 2'b00);
    axi_rd(12'h00C, 32'h01, 2'b00);
    axi_rd(12'h004, 32'h01, 2'b00);
    probe(32'h0008_0000, 2'd2, 3'd5, 1'b0);
    probe(32'h0005_0000, 2'd2, 3'd0, 1'b0);
    probe(32'h0004_0000, 2'd2, 3'd3, 1'b0);
    boot(3'h0, 8'h07, 4'h2);
    axi_rd(12'h004, 32'h07, 2'b00);
    probe(32'h0020_0000, 2'd2, 3'd0, 1'b0);
    probe(32'h0008_0000, 2'd2, 3'd4, 1'b0);
    boot(3'h1, 8'h02, 4'h1);
    chk({31'h0, err}, 32'h1);
    results();
  end
endmodule
